// ==== shared/ccp_defines.svh ====
// Register offsets, field positions, mode codes and reset values of the capture/compare unit
`ifndef CCP_DEFINES_SVH
`define CCP_DEFINES_SVH

// Register offsets
`define REG_CTRL_ONE 8'h17
`define REG_CTRL_TWO 8'h1D
`define REG_CAPL_ONE 8'h15
`define REG_CAPH_ONE 8'h16
`define REG_CAPL_TWO 8'h1B
`define REG_CAPH_TWO 8'h1C
`define REG_FLAG_ONE 8'h0C
`define REG_FLAG_TWO 8'h0D

// Flag bit positions within the flag registers
`define FLAG_BIT_ONE 2
`define FLAG_BIT_TWO 0

// Control field positions
`define CTRL_MODE_HI 3
`define CTRL_DUTY_HI 5
`define CTRL_DUTY_LO 4

// Mode codes
`define MODE_OFF 4'h0
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_DIV4 4'h6
`define MODE_CAP_DIV16 4'h7
`define MODE_CMP_SET 4'h8
`define MODE_CMP_CLR 4'h9
`define MODE_CMP_SOFT 4'hA
`define MODE_CMP_TRIG 4'hB
`define GROUP_CAP 2'h1
`define GROUP_CMP 2'h2
`define GROUP_PWM 2'h3

// Prescaler terminal counts
`define DIV4_LAST 2'h3
`define DIV16_LAST 4'hF

// Reset values
`define CTRL_RESET 6'h00
`define CAP_RESET 16'h0000
`define PRE_RESET 4'h0
`define BYTE_ZERO 8'h00

`endif

// ==== shared/ccp_pkg.sv ====
// Types shared by the capture/compare unit
package ccp_pkg;
    typedef logic [5:0] ctrl_type;
    typedef logic [3:0] mode_type;
    typedef logic [15:0] word_type;
    typedef logic [3:0] pre_type;
endpackage : ccp_pkg

// ==== core/capture_compare_mode_control.sv ====
// Mode control, capture and compare path of a two-unit capture/compare/PWM block
`timescale 1ns/1ps
`include "ccp_defines.svh"
module capture_compare_mode_control
    import ccp_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Timer one interface
    input wire logic [15:0] timer_one_count,
    output logic timer_one_clear,
    input wire logic adc_enabled,
    output logic adc_start,
    // Pins, one bit per unit
    input wire logic [1:0] capture_pin,
    output logic [1:0] compare_out,
    // Status and duty cycle
    output logic [1:0] unit_event_flag,
    output logic [1:0] pwm_active,
    output logic [9:0] duty_one,
    output logic [9:0] duty_two
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and qualified edges

    logic [1:0] s1_r;
    logic [1:0] s2_r;
    logic [1:0] s3_r;
    logic [1:0] lvl_r;
    logic [1:0] lvl_nxt;
    logic [1:0] rise;
    logic [1:0] fall;

    // Three stages; the pin level is what counts, whoever drives it
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            s1_r <= 2'h0;
            s2_r <= 2'h0;
            s3_r <= 2'h0;
        end
        else
        begin
            s1_r <= capture_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A change counts once stages two and three agree
    always_comb
    begin
        lvl_nxt = lvl_r;
        rise = 2'h0;
        fall = 2'h0;
        for (int i = 0; i < 2; i++)
        begin
            if (s2_r[i] == s3_r[i])
            begin
                lvl_nxt[i] = s3_r[i];
                rise[i] = s3_r[i] & ~lvl_r[i];
                fall[i] = ~s3_r[i] & lvl_r[i];
            end
        end
    end

    // Settled level register
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            lvl_r <= 2'h0;
        else
            lvl_r <= lvl_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Unit state

    ctrl_type ctrl_r [2];
    ctrl_type ctrl_nxt [2];
    word_type cap_r [2];
    word_type cap_nxt [2];
    pre_type pre_r [2];
    pre_type pre_nxt [2];
    logic [1:0] flag_r;
    logic [1:0] flag_nxt;
    logic [1:0] out_r;
    logic [1:0] out_nxt;
    logic [1:0] hit_r;
    logic [1:0] hit_nxt;
    logic clear_r;
    logic clear_nxt;
    logic adc_r;
    logic adc_nxt;

    // Next state of both units: bus writes first, hardware events win
    always_comb
    begin
        mode_type m;
        logic [1:0] grp;
        logic ev;
        logic eq;
        logic match;
        logic [7:0] a_ctrl;
        logic [7:0] a_capl;
        logic [7:0] a_caph;
        logic [7:0] a_flag;
        int fbit;
        m = `MODE_OFF;
        grp = 2'h0;
        ev = 1'b0;
        eq = 1'b0;
        match = 1'b0;
        a_ctrl = `REG_CTRL_ONE;
        a_capl = `REG_CAPL_ONE;
        a_caph = `REG_CAPH_ONE;
        a_flag = `REG_FLAG_ONE;
        fbit = `FLAG_BIT_ONE;
        clear_nxt = 1'b0;
        adc_nxt = 1'b0;
        flag_nxt = flag_r;
        out_nxt = out_r;
        hit_nxt = hit_r;
        for (int i = 0; i < 2; i++)
        begin
            ctrl_nxt[i] = ctrl_r[i];
            cap_nxt[i] = cap_r[i];
            pre_nxt[i] = pre_r[i];
            a_ctrl = (i == 0) ? `REG_CTRL_ONE : `REG_CTRL_TWO;
            a_capl = (i == 0) ? `REG_CAPL_ONE : `REG_CAPL_TWO;
            a_caph = (i == 0) ? `REG_CAPH_ONE : `REG_CAPH_TWO;
            a_flag = (i == 0) ? `REG_FLAG_ONE : `REG_FLAG_TWO;
            fbit = (i == 0) ? `FLAG_BIT_ONE : `FLAG_BIT_TWO;
            m = ctrl_r[i][`CTRL_MODE_HI:0];
            grp = m[3:2];
            // Software writes
            if (wr && addr == a_ctrl)
                ctrl_nxt[i] = wdata[`CTRL_DUTY_HI:0];
            if (wr && addr == a_capl)
                cap_nxt[i][7:0] = wdata;
            if (wr && addr == a_caph)
                cap_nxt[i][15:8] = wdata;
            if (wr && addr == a_flag)
                flag_nxt[i] = wdata[fbit];
            // Capture event selection
            unique case (m)
                `MODE_CAP_FALL: ev = fall[i];
                `MODE_CAP_RISE: ev = rise[i];
                `MODE_CAP_DIV4: ev = rise[i] && pre_r[i][1:0] == `DIV4_LAST;
                `MODE_CAP_DIV16: ev = rise[i] && pre_r[i] == `DIV16_LAST;
                default: ev = 1'b0;
            endcase
            // Prescaler runs only in capture modes; kept across switches between capture modes
            if (grp != `GROUP_CAP)
                pre_nxt[i] = `PRE_RESET;
            else if (rise[i])
                pre_nxt[i] = pre_r[i] + 4'h1;
            // Edge detector keeps running across mode changes
            if (ev)
            begin
                cap_nxt[i] = timer_one_count;
                flag_nxt[i] = 1'b1;
            end
            // Compare on the first cycle of equality only
            eq = (grp == `GROUP_CMP) && (timer_one_count == cap_r[i]);
            match = eq && !hit_r[i];
            hit_nxt[i] = eq;
            if (match)
            begin
                flag_nxt[i] = 1'b1;
                unique case (m)
                    `MODE_CMP_SET: out_nxt[i] = 1'b1;
                    `MODE_CMP_CLR: out_nxt[i] = 1'b0;
                    `MODE_CMP_TRIG:
                    begin
                        clear_nxt = 1'b1;
                        if (i == 1)
                            adc_nxt = adc_enabled;
                    end
                    default: out_nxt[i] = out_r[i];
                endcase
            end
            // Off mode clears the compare hit state and forces the output low
            if (m == `MODE_OFF)
            begin
                out_nxt[i] = 1'b0;
                hit_nxt[i] = 1'b0;
            end
        end
    end

    // Unit registers
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < 2; i++)
            begin
                ctrl_r[i] <= `CTRL_RESET;
                cap_r[i] <= `CAP_RESET;
                pre_r[i] <= `PRE_RESET;
            end
            flag_r <= 2'h0;
            out_r <= 2'h0;
            hit_r <= 2'h0;
            clear_r <= 1'b0;
            adc_r <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                ctrl_r[i] <= ctrl_nxt[i];
                cap_r[i] <= cap_nxt[i];
                pre_r[i] <= pre_nxt[i];
            end
            flag_r <= flag_nxt;
            out_r <= out_nxt;
            hit_r <= hit_nxt;
            clear_r <= clear_nxt;
            adc_r <= adc_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port

    logic [7:0] rsel;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // Read selection; unmapped addresses and idle cycles give zero
    always_comb
    begin
        rsel = `BYTE_ZERO;
        unique case (addr)
            `REG_CTRL_ONE: rsel = {2'h0, ctrl_r[0]};
            `REG_CTRL_TWO: rsel = {2'h0, ctrl_r[1]};
            `REG_CAPL_ONE: rsel = cap_r[0][7:0];
            `REG_CAPH_ONE: rsel = cap_r[0][15:8];
            `REG_CAPL_TWO: rsel = cap_r[1][7:0];
            `REG_CAPH_TWO: rsel = cap_r[1][15:8];
            `REG_FLAG_ONE: rsel[`FLAG_BIT_ONE] = flag_r[0];
            `REG_FLAG_TWO: rsel[`FLAG_BIT_TWO] = flag_r[1];
            default: rsel = `BYTE_ZERO;
        endcase
        rdata_nxt = rd ? rsel : `BYTE_ZERO;
    end

    // Read data register
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            rdata_r <= `BYTE_ZERO;
        else
            rdata_r <= rdata_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // PWM duty: low capture byte above control bits 5-4
    assign pwm_active[0] = ctrl_r[0][`CTRL_MODE_HI:2] == `GROUP_PWM;
    assign pwm_active[1] = ctrl_r[1][`CTRL_MODE_HI:2] == `GROUP_PWM;
    assign duty_one = {cap_r[0][7:0], ctrl_r[0][`CTRL_DUTY_HI:`CTRL_DUTY_LO]};
    assign duty_two = {cap_r[1][7:0], ctrl_r[1][`CTRL_DUTY_HI:`CTRL_DUTY_LO]};

    // Registered status and strobes
    assign rdata = rdata_r;
    assign unit_event_flag = flag_r;
    assign compare_out = out_r;
    assign timer_one_clear = clear_r;
    assign adc_start = adc_r;

endmodule : capture_compare_mode_control

// ==== verification/ccp_monitor.sv ====
// Concurrent checks on the ports of the capture/compare mode control block
`timescale 1ns/1ps
module ccp_monitor
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // Unit outputs
    input wire logic timer_one_clear,
    input wire logic adc_start,
    input wire logic [1:0] compare_out,
    input wire logic [1:0] unit_event_flag,
    input wire logic [1:0] pwm_active,
    input wire logic [9:0] duty_one
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////
    // Register and mode checks
    a_ctrl_high_zero: assert property ($past(rd) && $past(addr) == 8'h17 |-> rdata[7:6] == 2'h0)
        else $error("control top bits not zero");
    a_pwm_duty_bits: assert property (wr && addr == 8'h17 && wdata[3:2] == 2'h3
        |=> pwm_active[0] && duty_one[1:0] == $past(wdata[5:4])) else $error("duty bits wrong");
    a_zero_out_low: assert property (wr && addr == 8'h17 && wdata[3:0] == 4'h0
        |-> ##2 compare_out[0] == 1'b0) else $error("output not forced low");
    a_set_with_flag: assert property ($rose(compare_out[0]) |-> unit_event_flag[0])
        else $error("output set without flag");

    ////////////////////////////////////////////////////////////////
    // Trigger pulses and sticky flags
    a_clear_one_cycle: assert property (timer_one_clear |=> !timer_one_clear)
        else $error("timer clear longer than one cycle");
    a_adc_with_clear: assert property (adc_start |-> timer_one_clear)
        else $error("conversion start without trigger");
    a_flag_one_sticky: assert property ($fell(unit_event_flag[0]) && $past(reset_n)
        |-> $past(wr) && $past(addr) == 8'h0C && !$past(wdata[2])) else $error("flag one cleared by hardware");
    a_flag_two_sticky: assert property ($fell(unit_event_flag[1]) && $past(reset_n)
        |-> $past(wr) && $past(addr) == 8'h0D && !$past(wdata[0])) else $error("flag two cleared by hardware");

    // Main scenarios reached
    c_capture: cover property ($rose(unit_event_flag[0]));
    c_trigger: cover property (timer_one_clear && adc_start);
    c_pwm: cover property ($rose(pwm_active[0]));
endmodule : ccp_monitor

bind capture_compare_mode_control ccp_monitor u_monitor (.clock(clock), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .timer_one_clear(timer_one_clear), .adc_start(adc_start),
    .compare_out(compare_out), .unit_event_flag(unit_event_flag), .pwm_active(pwm_active), .duty_one(duty_one));

// ==== verification/pin_source.sv ====
// External signal source that drives the capture pins
`timescale 1ns/1ps
module pin_source
(
    // Clock and requested level
    input wire logic clock,
    input wire logic [1:0] level,
    // Pins towards the unit
    output logic [1:0] capture_pin
);
    // Pin acts as a pure input driven from outside
    always_ff @(posedge clock)
        capture_pin <= level;
endmodule : pin_source

// ==== verification/testbench.sv ====
// Self-checking bench of the capture/compare mode control block
`timescale 1ns/1ps
`include "ccp_defines.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end
module testbench;
    import ccp_pkg::*;
    typedef struct {mode_type m; int n; word_type t; logic f;} row_type;
    logic clock, reset_n, wr, rd, adc_enabled, timer_one_clear, adc_start;
    logic [7:0] addr, wdata, rdata, r, h;
    word_type timer_one_count, prev;
    logic [1:0] level, capture_pin, compare_out, unit_event_flag, pwm_active;
    logic [9:0] duty_one, duty_two;
    int n_mismatch, compares, cycles, k;
    mode_type cm [4] = '{`MODE_CMP_SET, `MODE_CMP_SOFT, `MODE_CMP_CLR, `MODE_CMP_SET};
    logic co [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    row_type rows [7] = '{'{`MODE_CAP_FALL, 1, 16'h1234, 1'b1}, '{`MODE_CAP_RISE, 1, 16'hABCD, 1'b1},
        '{`MODE_CAP_DIV4, 3, 16'h1111, 1'b0}, '{`MODE_CAP_DIV4, 4, 16'h2222, 1'b1},
        '{`MODE_CAP_DIV16, 15, 16'h3333, 1'b0}, '{`MODE_CAP_DIV16, 16, 16'h4444, 1'b1},
        '{`MODE_OFF, 2, 16'h5555, 1'b0}};

    capture_compare_mode_control dut (.clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .timer_one_count(timer_one_count), .timer_one_clear(timer_one_clear),
        .adc_enabled(adc_enabled), .adc_start(adc_start), .capture_pin(capture_pin), .compare_out(compare_out),
        .unit_event_flag(unit_event_flag), .pwm_active(pwm_active), .duty_one(duty_one), .duty_two(duty_two));
    pin_source src (.clock(clock), .level(level), .capture_pin(capture_pin));

    ////////////////////////////////////////////////////////////////
    // Bus tasks and pin pulses
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
        @(posedge clock);
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        @(posedge clock);
        d = rdata;
    endtask : rd_reg

    task automatic pulses(input int n);
        repeat (n)
        begin
            level <= 2'h3;
            repeat (4) @(posedge clock);
            level <= 2'h0;
            repeat (4) @(posedge clock);
        end
        repeat (6) @(posedge clock);
    endtask : pulses

    task automatic wrap_up;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////
    // Clock and hang limit
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {reset_n, wr, rd, adc_enabled, addr, wdata, level, timer_one_count, prev} = '0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        // Capture modes, timer held by the bench in its clock domain
        foreach (rows[i])
        begin
            wr_reg(`REG_CTRL_ONE, 8'h00);
            wr_reg(`REG_CTRL_ONE, {4'h0, rows[i].m});
            wr_reg(`REG_FLAG_ONE, 8'h00);
            timer_one_count <= rows[i].t;
            pulses(rows[i].n);
            rd_reg(`REG_FLAG_ONE, r);
            `CHK(r[2], rows[i].f)
            if (rows[i].f)
                prev = rows[i].t;
            rd_reg(`REG_CAPH_ONE, h);
            rd_reg(`REG_CAPL_ONE, r);
            `CHK({h, r}, prev)
        end
        // Direct prescaler switch keeps the count
        wr_reg(`REG_CTRL_ONE, 8'h00);
        wr_reg(`REG_CTRL_ONE, {4'h0, `MODE_CAP_DIV16});
        pulses(15);
        wr_reg(`REG_CTRL_ONE, {4'h0, `MODE_CAP_DIV4});
        wr_reg(`REG_FLAG_ONE, 8'h00);
        pulses(1);
        `CHK(unit_event_flag[0], 1'b1)
        // Compare actions on unit one
        wr_reg(`REG_CAPL_ONE, 8'h40);
        wr_reg(`REG_CAPH_ONE, 8'h12);
        foreach (cm[i])
        begin
            timer_one_count <= 16'h123F;
            wr_reg(`REG_CTRL_ONE, {4'h0, cm[i]});
            wr_reg(`REG_FLAG_ONE, 8'h00);
            timer_one_count <= 16'h1240;
            repeat (3) @(posedge clock);
            `CHK(compare_out[0], co[i])
            `CHK(unit_event_flag[0], 1'b1)
        end
        wr_reg(`REG_CTRL_ONE, 8'h00);
        @(posedge clock);
        `CHK(compare_out[0], 1'b0)
        // Special event trigger on unit two
        adc_enabled <= 1'b1;
        wr_reg(`REG_CAPL_TWO, 8'h40);
        wr_reg(`REG_CAPH_TWO, 8'h12);
        timer_one_count <= 16'h123F;
        wr_reg(`REG_CTRL_TWO, {4'h0, `MODE_CMP_TRIG});
        timer_one_count <= 16'h1240;
        k = 0;
        while (timer_one_clear !== 1'b1 && k < 10)
        begin
            @(posedge clock);
            k++;
        end
        `CHK(adc_start, 1'b1)
        @(posedge clock);
        `CHK(timer_one_clear, 1'b0)
        wr_reg(`REG_FLAG_TWO, 8'h00);
        rd_reg(`REG_FLAG_TWO, r);
        `CHK(r[0], 1'b0)
        // Register access, PWM duty and unmapped place
        wr_reg(`REG_CTRL_ONE, 8'hFF);
        rd_reg(`REG_CTRL_ONE, r);
        `CHK(r, 8'h3F)
        wr_reg(`REG_CAPL_ONE, 8'hA5);
        `CHK(pwm_active[0], 1'b1)
        `CHK(duty_one, 10'h297)
        wr_reg(`REG_CTRL_TWO, 8'h2C);
        `CHK(pwm_active, 2'h3)
        `CHK(duty_two, 10'h102)
        rd_reg(8'h30, r);
        `CHK(r, 8'h00)
        // Reset in mid-run clears control
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        rd_reg(`REG_CTRL_ONE, r);
        `CHK(r, 8'h00)
        `CHK(pwm_active, 2'h0)
        `CHK(unit_event_flag, 2'h0)
        wrap_up();
    end
endmodule : testbench
